// file: inc/monsec_params.svh
// constants for the monitor security gate
// assumes a 50 MHz system clock and a 9600 baud monitor link
`ifndef MONSEC_PARAMS_SVH
`define MONSEC_PARAMS_SVH
`define CLK_HZ 50000000
`define BAUD_RATE 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define CODE_BYTES 8
`define CODE_BASE_ADDR 16'hFFF6
`define CODE_LAST_ADDR 16'hFFFD
`define ERASED_BYTE 8'hFF
`define INVALID_BYTE 8'h00
`define FLAG_RAM_ADDR 8'h60
`define FLAG_BIT 6
`define BREAK_LOW_BITS 10
`endif

// file: inc/monsec_pkg.sv
// types for the monitor security gate
// assumes nothing beyond the params header
package monsec_pkg;
	typedef enum logic [4:0] {
		ST_WAIT_BYTES = 5'h01,
		ST_FETCH_CODE = 5'h02,
		ST_SEND_BREAK = 5'h04,
		ST_READY = 5'h08,
		ST_IDLE = 5'h10
	} gate_state_e;
	typedef logic [7:0] byte_t;
endpackage

// file: logic/monitor_security_gate.sv
// Functional notes
// - compare eight received bytes with stored code
// - full match unlocks reads and execution
// - satisfied survives all but power-on reset
// - mismatch: reads return invalid value
// - locked fetch triggers illegal-address reset
// - break sent only after eighth byte
// - set bit 6 of RAM $60
// - bulk erase leaves code bytes $FF
// - break is start plus nine low bits
// - link runs 9600 baud nrz both ways
//
// security gate for monitor mode entry
// assumes rst is power-on reset only; other resets arrive on sys_reset
`include "monsec_params.svh"
module monitor_security_gate
#(
	parameter int BIT_CYC = `BIT_CYCLES,
	parameter int NBYTES = `CODE_BYTES
) (
	// system
	input wire logic clk,
	input wire logic rst,
	input wire logic sys_reset,
	// monitor link
	input wire logic monitor_serial_receive_pin,
	output logic monitor_serial_transmit,
	// code memory port used to fetch stored code bytes
	output logic [15:0] code_addr,
	input wire monsec_pkg::byte_t code_data,
	// cpu access filtering
	input wire logic cpu_read,
	input wire logic cpu_fetch,
	input wire logic cpu_in_prog_mem,
	input wire monsec_pkg::byte_t prog_data,
	output monsec_pkg::byte_t read_data,
	output logic illegal_addr_reset,
	// status
	output logic security_ok,
	output logic ram_flag_write,
	output logic [7:0] ram_flag_addr,
	output logic [7:0] ram_flag_mask,
	output logic ready_for_cmd
);
	import monsec_pkg::*;
	typedef struct packed {
		gate_state_e st;
		logic [2:0] sync;
		logic rx_level;
		logic [3:0] idx;
		logic [3:0] fidx;
		logic match;
		logic sat;
		logic [63:0] rxb;
		logic [15:0] cnt;
		logic [3:0] bits;
		logic tx;
		logic [15:0] caddr;
		logic [7:0] rdata;
		logic ill;
		logic fw;
		logic rdy;
		logic [7:0] faddr;
		logic [7:0] fmask;
	} gate_s;
	gate_s s_reg, s_next;
	logic [7:0] rx_data;
	logic rx_valid;
	// the byte buffer and the compare index are sized for exactly eight code bytes
	if (NBYTES != 8) begin : g_bad_nbytes
		$error("monitor_security_gate: NBYTES must be 8");
	end
	if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad_bit_cyc
		$error("monitor_security_gate: bad BIT_CYC");
	end
	serial_rx #(.BIT_CYC(BIT_CYC)) u_rx (
		.clk(clk),
		.rst(rst),
		.rx_sync(s_reg.rx_level),
		.data(rx_data),
		.data_valid(rx_valid),
		.break_seen()
	);
	always_comb begin
		s_next = s_reg;
		s_next.fw = 1'b0;
		s_next.ill = 1'b0;
		// three-stage sync; level changes only when stages 2 and 3 agree
		s_next.sync = {s_reg.sync[1:0], monitor_serial_receive_pin};
		if (s_reg.sync[1] == s_reg.sync[2]) begin
			s_next.rx_level = s_reg.sync[2];
		end
		case (s_reg.st)
			ST_WAIT_BYTES: begin
				if (rx_valid) begin
					s_next.rxb = {s_reg.rxb[55:0], rx_data};
					s_next.idx = s_reg.idx + 4'h1;
					if (s_reg.idx == 4'(NBYTES - 1)) begin
						s_next.st = ST_FETCH_CODE;
						s_next.fidx = 4'h0;
						s_next.match = 1'b1;
						s_next.caddr = `CODE_BASE_ADDR;
					end
				end
			end
			ST_FETCH_CODE: begin
				// erased code compares like any other stored bytes
				// one cycle memory latency: data for caddr seen next cycle
				if (s_reg.fidx != 4'h0) begin
					if (code_data != s_reg.rxb[8 * (NBYTES - int'(s_reg.fidx)) +: 8]) begin
						s_next.match = 1'b0;
					end
				end
				s_next.fidx = s_reg.fidx + 4'h1;
				s_next.caddr = s_reg.caddr + 16'h0001;
				if (s_reg.fidx == 4'(NBYTES)) begin
					s_next.st = ST_SEND_BREAK;
					s_next.cnt = 16'(BIT_CYC - 1);
					s_next.bits = 4'h0;
					s_next.tx = 1'b0;
					if (s_next.match) begin
						s_next.sat = 1'b1;
						s_next.fw = 1'b1;
					end
				end
			end
			ST_SEND_BREAK: begin
				if (s_reg.cnt != 16'h0000) begin
					s_next.cnt = s_reg.cnt - 16'h0001;
				end else if (s_reg.bits == 4'(`BREAK_LOW_BITS - 1)) begin
					s_next.tx = 1'b1;
					s_next.st = ST_READY;
				end else begin
					s_next.cnt = 16'(BIT_CYC - 1);
					s_next.bits = s_reg.bits + 4'h1;
				end
			end
			ST_READY: begin
				s_next.rdy = 1'b1;
			end
			ST_IDLE: begin
				s_next.rdy = 1'b1;
			end
			default: begin
				s_next.st = ST_WAIT_BYTES;
			end
		endcase
		// non-por reset keeps satisfied, no new entry
		// failed gate stays failed until por
		if (sys_reset) begin
			s_next.st = s_reg.sat ? ST_IDLE : ST_READY;
			s_next.tx = 1'b1;
		end
		s_next.rdata = (cpu_in_prog_mem && !s_reg.sat) ? `INVALID_BYTE : prog_data;
		// locked fetch resets
		// a fetch counts whether or not read is raised with it, so no opcode slips past
		if (cpu_fetch && cpu_in_prog_mem && !s_reg.sat && !cpu_read) begin
			s_next.ill = 1'b1;
		end
		if (cpu_fetch && cpu_in_prog_mem && !s_reg.sat && cpu_read) begin
			s_next.ill = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '{st: ST_WAIT_BYTES, sync: 3'h7, rx_level: 1'b1, tx: 1'b1,
				faddr: `FLAG_RAM_ADDR, fmask: 8'h01 << `FLAG_BIT, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end
	assign monitor_serial_transmit = s_reg.tx;
	assign code_addr = s_reg.caddr;
	assign read_data = s_reg.rdata;
	assign illegal_addr_reset = s_reg.ill;
	assign security_ok = s_reg.sat;
	assign ram_flag_write = s_reg.fw;
	assign ram_flag_addr = s_reg.faddr;
	assign ram_flag_mask = s_reg.fmask;
	assign ready_for_cmd = s_reg.rdy;
endmodule // monitor_security_gate

// file: logic/serial_rx.sv
// nrz receiver for the monitor link, 8n1 at the link rate
// assumes rx_sync already synchronised; also flags a break
`include "monsec_params.svh"
module serial_rx #(
	parameter int BIT_CYC = `BIT_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic rst,
	// line
	input wire logic rx_sync,
	// received data
	output logic [7:0] data,
	output logic data_valid,
	output logic break_seen
);
	typedef struct packed {
		logic busy;
		logic [15:0] cnt;
		logic [3:0] bitn;
		logic [8:0] sh;
		logic [7:0] data;
		logic valid;
		logic brk;
	} rx_s;
	rx_s s_reg, s_next;
	// the counter is 16 bits and the half-bit start delay needs a few cycles
	if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad_bit_cyc
		$error("serial_rx: bad BIT_CYC");
	end
	always_comb begin
		s_next = s_reg;
		s_next.valid = 1'b0;
		s_next.brk = 1'b0;
		if (!s_reg.busy) begin
			if (!rx_sync) begin
				s_next.busy = 1'b1;
				s_next.cnt = 16'(BIT_CYC / 2);
				s_next.bitn = 4'h0;
			end
		end else if (s_reg.cnt != 16'h0000) begin
			s_next.cnt = s_reg.cnt - 16'h0001;
		end else begin
			s_next.cnt = 16'(BIT_CYC - 1);
			if (s_reg.bitn == 4'h0 && rx_sync) begin
				s_next.busy = 1'b0;
			end else if (s_reg.bitn == 4'h9) begin
				s_next.busy = 1'b0;
				if (!rx_sync && s_reg.sh == 9'h000) begin
					s_next.brk = 1'b1;
				end else if (rx_sync) begin
					s_next.data = s_reg.sh[8:1];
					s_next.valid = 1'b1;
				end
			end else begin
				s_next.sh = {rx_sync, s_reg.sh[8:1]};
				s_next.bitn = s_reg.bitn + 4'h1;
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign data = s_reg.data;
	assign data_valid = s_reg.valid;
	assign break_seen = s_reg.brk;
endmodule // serial_rx

// file: verif/host_model.sv
// host end of the monitor link: sends 8n1 bytes, lsb first
// assumes bit time given in system clock cycles
module host_model #(parameter int BIT_CYC = 8) (
	// system
	input wire logic clk,
	// line
	output logic rx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rx_line = 1'b1;
	// nrz framing at the shared rate
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			repeat (BIT_CYC) @(negedge clk);
			rx_line = f[i];
		end
	endtask
endmodule // host_model

// file: verif/monitor_security_gate_assertions.sv
// port checks for the monitor security gate
// assumes rst is power-on reset and BIT_CYC matches the gate
module monitor_security_gate_assertions #(parameter int BIT_CYC = 8) (
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic sys_reset,
	input wire logic monitor_serial_transmit,
	input wire logic cpu_read,
	input wire logic cpu_fetch,
	input wire logic cpu_in_prog_mem,
	input wire monsec_pkg::byte_t prog_data,
	input wire monsec_pkg::byte_t read_data,
	input wire logic illegal_addr_reset,
	input wire logic security_ok,
	input wire logic ram_flag_write,
	input wire logic [7:0] ram_flag_addr,
	input wire logic [7:0] ram_flag_mask
);
	timeunit 1ns;
	timeprecision 1ns;
	int low_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence locked_fetch_s;
		cpu_fetch && cpu_in_prog_mem && !security_ok;
	endsequence
	// a counter, since the break is far longer than a repetition can span
	always_ff @(posedge clk or posedge rst) begin
		if (rst) low_cnt <= 0;
		else low_cnt <= monitor_serial_transmit ? 0 : low_cnt + 1;
	end
	flag_target_a: assert property (ram_flag_write |-> ram_flag_addr == 8'h60 && ram_flag_mask == 8'h40)
		else $error("flag write aims at wrong bit");
	ok_with_flag_a: assert property ($rose(security_ok) |-> ram_flag_write)
		else $error("unlock without flag write");
	ok_sticky_a: assert property (security_ok |=> security_ok)
		else $error("unlock lost without power-on reset");
	locked_read_a: assert property (cpu_read && cpu_in_prog_mem && !security_ok |=> read_data == 8'h00)
		else $error("locked read leaked data");
	open_read_a: assert property (cpu_read && cpu_in_prog_mem && security_ok |=> read_data == $past(prog_data))
		else $error("unlocked read wrong");
	fetch_reset_a: assert property (locked_fetch_s |=> illegal_addr_reset)
		else $error("locked fetch gave no reset");
	reset_cause_a: assert property (illegal_addr_reset |-> $past(cpu_fetch && cpu_in_prog_mem && !security_ok))
		else $error("reset pulse without locked fetch");
	break_len_a: assert property ($rose(monitor_serial_transmit) && !$past(sys_reset) |-> low_cnt == 10 * BIT_CYC)
		else $error("break length wrong");
endmodule // monitor_security_gate_assertions

bind monitor_security_gate monitor_security_gate_assertions #(.BIT_CYC(BIT_CYC)) chk (.clk(clk), .rst(rst),
	.sys_reset(sys_reset), .monitor_serial_transmit(monitor_serial_transmit), .cpu_read(cpu_read),
	.cpu_fetch(cpu_fetch), .cpu_in_prog_mem(cpu_in_prog_mem), .prog_data(prog_data), .read_data(read_data),
	.illegal_addr_reset(illegal_addr_reset), .security_ok(security_ok), .ram_flag_write(ram_flag_write),
	.ram_flag_addr(ram_flag_addr), .ram_flag_mask(ram_flag_mask));

// file: verif/monitor_security_gate_tb.sv
// self-checking bench for the monitor security gate
// assumes host_model and a code memory answering one cycle late
module monitor_security_gate_tb import monsec_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, sys_reset, rxd, tx, cpu_read, cpu_fetch, cpu_in_prog_mem, ill, sec_ok, flag_wr, rdy;
	logic [15:0] code_addr, off, off_d;
	logic erased;
	logic [7:0] flag_addr, flag_mask;
	byte_t code_data = 8'h00;
	byte_t prog_data, read_data;
	byte_t code [8] = '{8'h3A, 8'hC5, 8'h01, 8'hFE, 8'h77, 8'h80, 8'h5A, 8'h12}; // all user data
	int n_mismatch = 0, checked = 0, n_flag = 0;
	host_model #(.BIT_CYC(8)) host (.clk(clk), .rx_line(rxd));
	monitor_security_gate #(.BIT_CYC(8), .NBYTES(8)) uut (.clk(clk), .rst(rst), .sys_reset(sys_reset),
		.monitor_serial_receive_pin(rxd), .monitor_serial_transmit(tx), .code_addr(code_addr),
		.code_data(code_data), .cpu_read(cpu_read), .cpu_fetch(cpu_fetch), .cpu_in_prog_mem(cpu_in_prog_mem),
		.prog_data(prog_data), .read_data(read_data), .illegal_addr_reset(ill), .security_ok(sec_ok),
		.ram_flag_write(flag_wr), .ram_flag_addr(flag_addr), .ram_flag_mask(flag_mask), .ready_for_cmd(rdy));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	assign off = code_addr - 16'hFFF6;
	// code memory answers one cycle after the address, as the gate expects
	always @(negedge clk) begin
		off_d <= off;
		if (erased) code_data <= 8'hFF;
		else code_data <= off_d < 16'h0008 ? code[off_d[2:0]] : ~code_data;
		if (flag_wr === 1'b1) n_flag++;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_tx(input logic lvl, output int n);
		n = 0;
		for (int i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (tx === lvl) begin
				n = i + 1;
				return;
			end
		end
		n_mismatch++;
		$display("mismatch tx wait expected %b seen %b", lvl, tx);
		conclude;
	endtask
	task automatic access(input logic fetch, input logic inmem, input logic [7:0] exp);
		cpu_read = !fetch;
		cpu_fetch = fetch;
		cpu_in_prog_mem = inmem;
		@(negedge clk);
		cpu_read = 1'b0;
		cpu_fetch = 1'b0;
		check(fetch ? "illegal_addr_reset" : "read_data", exp, fetch ? {7'h00, ill} : read_data);
		// let an edge pass so a following call never drives these lines twice in one step
		@(negedge clk);
	endtask
	// one power-on entry; bad flips one bit of the last code byte, ers models an erased array
	task automatic entry(input logic bad, input logic ers);
		int n_low;
		rst = 1'b1;
		erased = ers;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		n_flag = 0;
		for (int k = 0; k < 7; k++) host.send_byte(ers ? 8'hFF : code[k]);
		check("tx before eighth", 8'h01, {7'h00, tx});
		host.send_byte((ers ? 8'hFF : code[7]) ^ {7'h00, bad});
		wait_tx(1'b0, n_low);
		check("security_ok", {7'h00, !bad}, {7'h00, sec_ok});
		wait_tx(1'b1, n_low);
		check("break cycles", 8'h50, n_low[7:0]);
		check("flag writes", {7'h00, !bad}, n_flag[7:0]);
		check("ram_flag_addr", 8'h60, flag_addr);
		check("ram_flag_mask", 8'h40, flag_mask);
		// ready follows one cycle after the line returns high
		@(negedge clk);
		check("ready_for_cmd", 8'h01, {7'h00, rdy});
		access(1'b0, 1'b1, bad ? 8'h00 : 8'h5C);
		access(1'b1, 1'b1, {7'h00, bad});
		access(1'b0, 1'b0, 8'h5C);
		access(1'b1, 1'b0, 8'h00);
		sys_reset = 1'b1;
		@(negedge clk);
		sys_reset = 1'b0;
		repeat (2) @(negedge clk);
		check("security_ok kept", {7'h00, !bad}, {7'h00, sec_ok});
		$display("test entry bad=%0d erased=%0d done", bad, ers);
	endtask
	initial begin
		sys_reset = 1'b0;
		cpu_read = 1'b0;
		cpu_fetch = 1'b0;
		cpu_in_prog_mem = 1'b1;
		prog_data = 8'h5C;
		entry(1'b0, 1'b0);
		entry(1'b1, 1'b0);
		entry(1'b0, 1'b1);
		conclude;
	end
endmodule // monitor_security_gate_tb
